// ==== lpddr_guard_params.svh ====
`ifndef LPDDR_GUARD_PARAMS_SVH
`define LPDDR_GUARD_PARAMS_SVH

`define MCLK_PERIOD_NS 10
`define CK_DIV 2
`define TCK_NS (`MCLK_PERIOD_NS * `CK_DIV)
`define TCK2CYC(t) ((t) * `CK_DIV)
`define NS2CYC(ns) ((((ns) + `TCK_NS - 1) / `TCK_NS) * `CK_DIV)

`define BANKS 4
`define MODE_PROGRAM_GAP_TCK 2
`define ROW_OPEN_TIME_MIN_FAST_NS 40
`define ROW_OPEN_TIME_MIN_SLOW_NS 42
`define ROW_OPEN_TIME_MAX_NS 70000
`define ROW_FORCE_MARGIN 64
`define PRECHARGE_GAP_FAST_NS 15
`define PRECHARGE_GAP_SLOW_NS 18
`define REFRESH_CYCLE_GAP_NS 72
`define ACTIVATE_TO_ACCESS_GAP_FAST_NS 15
`define ACTIVATE_TO_ACCESS_GAP_SLOW_NS 18
`define CROSS_BANK_ACTIVATE_GAP_FAST_NS 10
`define CROSS_BANK_ACTIVATE_GAP_SLOW_NS 12
`define WRITE_TO_READ_GAP_TCK 1
`define SELF_REFRESH_EXIT_GAP_NS 120
`define POWERDOWN_EXIT_GAP_FAST_TCK 2
`define POWERDOWN_EXIT_GAP_SLOW_TCK 1
`define CLOCK_ENABLE_PULSE_MIN_TCK 1
`define AVERAGE_REFRESH_INTERVAL_NS 7800
`define REFRESH_POSTPONE_MAX 8
`define STATUS_SELECT_TO_READ_GAP_TCK 2
`define WRITE_STROBE_FIRST_EDGE_TCK 1
`define AUTOPRECHARGE_WRITE_MIN_TCK 3
`define WRITE_RECOVERY_TIME_NS 15
`define STROBE_FRAME_EXTRA 4
`define STROBE_DRIVE_EXTRA 2

`define CMD_NOP 3'h7
`define CMD_ACT 3'h3
`define CMD_RD  3'h5
`define CMD_WR  3'h4
`define CMD_PRE 3'h2
`define CMD_REF 3'h1
`define CMD_MRS 3'h0
`define AUTO_PRECHARGE_BIT 10
`define STATUS_SELECT_BA 2'h1

`endif

// ==== lpddr_guard_pkg.sv ====
`include "lpddr_guard_params.svh"
package lpddr_guard_pkg;
	typedef enum logic [3:0] {
		REQ_ACTIVATE, REQ_READ, REQ_WRITE, REQ_WRITE_AP, REQ_PRECHARGE,
		REQ_MODE_SET, REQ_STATUS_READ, REQ_SELF_REFRESH_ENTER,
		REQ_SELF_REFRESH_EXIT, REQ_POWERDOWN_ENTER, REQ_POWERDOWN_EXIT
	} req_cmd_type;

	typedef enum logic [3:0] {
		MODE_RUN          = 4'h1,
		MODE_STATUS_READ  = 4'h2,
		MODE_POWERDOWN    = 4'h4,
		MODE_SELF_REFRESH = 4'h8
	} mode_type;

	typedef struct packed {
		req_cmd_type cmd;
		logic [1:0]  bank;
		logic [12:0] addr;
	} req_type;

	typedef struct packed {
		logic        cke;
		logic        cs_n;
		logic [2:0]  cmd;
		logic [1:0]  ba;
		logic [12:0] addr;
	} pins_type;

	typedef struct packed {
		logic                        phase;
		logic                        ck_n;
		mode_type                    mode;
		pins_type                    pins;
		logic [`BANKS-1:0]           open;
		logic [`BANKS-1:0][15:0]     age;
		logic [`BANKS-1:0][15:0]     act_rdy;
		logic [15:0]                 quiet;
		logic [15:0]                 rfc;
		logic [15:0]                 rrd;
		logic [15:0]                 wtr;
		logic [15:0]                 cke_hold;
		logic [15:0]                 refi;
		logic [3:0]                  debt;
		logic [7:0]                  dqs_cnt;
		logic                        dqs;
		logic                        dqs_oe_n;
	} guard_type;
endpackage

// ==== lpddr_command_timing_guard.sv ====
`timescale 1ns/10ps
`include "lpddr_guard_params.svh"
// Contract
// - After a mode register command, wait two clock cycles before any command.
// - Open row stays open at least 40/42 ns, at most 70000 ns.
// - Same-bank activations spaced by open-row minimum plus precharge time.
// - After refresh, wait 72 ns before activation or another refresh.
// - Read or write waits 15/18 ns after its bank's activation.
// - Activations of different banks spaced at least 10/12 ns.
// - Read waits one clock after the last write data.
// - After leaving self refresh, wait 120 ns before the next command.
// - After leaving power-down, wait 2/1 clocks before the next command.
// - Clock-enable high and low pulses last at least one clock.
// - Refresh all rows in 64 ms, one refresh per 7.8 us on average.
// - Status read: select by mode command, wait 2 clocks, then latency plus one.
// - First write strobe edge comes 0.75 to 1.25 clocks after the write.
// - Auto-precharge write recovery is max of 3 and rounded recovery plus precharge.
// - At most eight refreshes postponed; gap never over eight intervals.
// - Clock keeps pulsing during the self-refresh exit wait.
// - Clock frequency changes only while stopped, in power-down or self refresh.
module lpddr_command_timing_guard
	import lpddr_guard_pkg::*;
#(
	parameter bit FAST_GRADE       = 1'b1,
	parameter int READ_LATENCY     = 3,
	parameter int BURST_LENGTH     = 4,
	parameter int ROW_OPEN_MAX_CYC = `NS2CYC(`ROW_OPEN_TIME_MAX_NS)
) (
	input  wire logic                    MCLK,
	input  wire logic                    RST,
	input  wire lpddr_guard_pkg::req_type REQ,
	input  wire logic                    REQ_VALID,
	output logic                         REQ_READY,
	output logic                         CK,
	output logic                         CK_N,
	output logic                         CKE,
	output logic                         CS_N,
	output logic                         RAS_N,
	output logic                         CAS_N,
	output logic                         WE_N,
	output logic [1:0]                   BA,
	output logic [12:0]                  ADDR,
	output logic                         DQS_O,
	output logic                         DQS_OE_N
);
	import lpddr_guard_pkg::*;

	// Figures below are in MCLK cycles, rounded up to whole command clocks, except DAL_SUM and DAL_TCK, which are in command clocks.
	localparam int RAS_I = FAST_GRADE ? `NS2CYC(`ROW_OPEN_TIME_MIN_FAST_NS)
		: `NS2CYC(`ROW_OPEN_TIME_MIN_SLOW_NS);
	localparam int RP_I = FAST_GRADE ? `NS2CYC(`PRECHARGE_GAP_FAST_NS)
		: `NS2CYC(`PRECHARGE_GAP_SLOW_NS);
	localparam int RCD_I = FAST_GRADE ? `NS2CYC(`ACTIVATE_TO_ACCESS_GAP_FAST_NS)
		: `NS2CYC(`ACTIVATE_TO_ACCESS_GAP_SLOW_NS);
	localparam int RRD_I = FAST_GRADE ? `NS2CYC(`CROSS_BANK_ACTIVATE_GAP_FAST_NS)
		: `NS2CYC(`CROSS_BANK_ACTIVATE_GAP_SLOW_NS);
	localparam int XP_I = FAST_GRADE ? `TCK2CYC(`POWERDOWN_EXIT_GAP_FAST_TCK)
		: `TCK2CYC(`POWERDOWN_EXIT_GAP_SLOW_TCK);
	localparam int DAL_SUM = (`NS2CYC(`WRITE_RECOVERY_TIME_NS) + RP_I) / `CK_DIV;
	localparam int DAL_TCK = (DAL_SUM > `AUTOPRECHARGE_WRITE_MIN_TCK) ? DAL_SUM
		: `AUTOPRECHARGE_WRITE_MIN_TCK;
	localparam int WR_END_I = `TCK2CYC(`WRITE_STROBE_FIRST_EDGE_TCK + BURST_LENGTH / 2);

	localparam logic [15:0] RAS_MIN   = 16'(RAS_I);
	localparam logic [15:0] RCD       = 16'(RCD_I);
	localparam logic [15:0] RC        = 16'(RAS_I + RP_I);
	localparam logic [15:0] RP_LD     = 16'(RP_I - 1);
	localparam logic [15:0] RC_LD     = 16'(RAS_I + RP_I - 1);
	localparam logic [15:0] RRD_LD    = 16'(RRD_I - 1);
	localparam logic [15:0] RFC_LD    = 16'(`NS2CYC(`REFRESH_CYCLE_GAP_NS) - 1);
	localparam logic [15:0] WTR_LD    = 16'(WR_END_I + `TCK2CYC(`WRITE_TO_READ_GAP_TCK) - 1);
	localparam logic [15:0] WRA_LD    = 16'(WR_END_I + `TCK2CYC(DAL_TCK) - 1);
	localparam logic [15:0] MRD_LD    = 16'(`TCK2CYC(`MODE_PROGRAM_GAP_TCK) - 1);
	localparam logic [15:0] SRR_LD    = 16'(`TCK2CYC(`STATUS_SELECT_TO_READ_GAP_TCK) - 1);
	localparam logic [15:0] SRC_LD    = 16'(`TCK2CYC(READ_LATENCY + 1) - 1);
	localparam logic [15:0] XSR_LD    = 16'(`NS2CYC(`SELF_REFRESH_EXIT_GAP_NS) - 1);
	localparam logic [15:0] XP_LD     = 16'(XP_I - 1);
	localparam logic [15:0] CKE_LD    = 16'(`TCK2CYC(`CLOCK_ENABLE_PULSE_MIN_TCK) - 1);
	localparam logic [15:0] REFI_LAST = 16'(`NS2CYC(`AVERAGE_REFRESH_INTERVAL_NS) - 1);
	localparam logic [15:0] ROW_FORCE = 16'(ROW_OPEN_MAX_CYC - `ROW_FORCE_MARGIN);
	localparam logic [3:0]  DEBT_MAX  = 4'(`REFRESH_POSTPONE_MAX);
	localparam logic [7:0]  DQS_LEN   = 8'(BURST_LENGTH + `STROBE_FRAME_EXTRA);
	localparam logic [7:0]  DQS_DRIVE = 8'(BURST_LENGTH + `STROBE_DRIVE_EXTRA);

	guard_type   st;
	guard_type   next;
	logic        issue;
	logic        take;
	logic        next_cke;
	logic        force_pre;
	logic        all_idle;
	logic [2:0]  icmd;
	logic [1:0]  iba;
	logic [1:0]  force_bank;
	logic [12:0] iaddr;

	function automatic logic [15:0] dec(input logic [15:0] x);
		dec = (x == 16'h0) ? 16'h0 : x - 16'h1;
	endfunction

	function automatic logic [15:0] mx(input logic [15:0] a, input logic [15:0] b);
		mx = (a > b) ? a : b;
	endfunction

	always_comb begin
		next = st;
		issue = 1'b0;
		take = 1'b0;
		icmd = `CMD_NOP;
		iba = 2'h0;
		iaddr = 13'h0;
		next_cke = st.pins.cke;
		force_pre = 1'b0;
		force_bank = 2'h0;
		all_idle = 1'b1;
		// The command clock is a free-running fixed divide of MCLK.
		next.phase = ~st.phase;
		next.ck_n = st.phase;
		for (int b = 0; b < `BANKS; b++) begin
			if (st.age[b] != 16'hffff) begin
				next.age[b] = st.age[b] + 16'h1;
			end
			next.act_rdy[b] = dec(st.act_rdy[b]);
			if (st.open[b] || st.act_rdy[b] != 16'h0) begin
				all_idle = 1'b0;
			end
			// Close a row before its open limit, or to make room for an overdue refresh.
			if (st.open[b] && st.age[b] >= RAS_MIN && !force_pre &&
					(st.age[b] >= ROW_FORCE || st.debt == DEBT_MAX)) begin
				force_pre = 1'b1;
				force_bank = 2'(b);
			end
		end
		next.quiet = dec(st.quiet);
		next.rfc = dec(st.rfc);
		next.rrd = dec(st.rrd);
		next.wtr = dec(st.wtr);
		next.cke_hold = dec(st.cke_hold);
		next.dqs_cnt = (st.dqs_cnt == 8'h0) ? 8'h0 : st.dqs_cnt - 8'h1;
		if (st.mode == MODE_SELF_REFRESH) begin
			next.refi = 16'h0;
			next.debt = 4'h0;
		end else if (st.refi == REFI_LAST) begin
			next.refi = 16'h0;
			if (st.debt != DEBT_MAX) begin
				next.debt = st.debt + 4'h1;
			end
		end else begin
			next.refi = st.refi + 16'h1;
		end
		if (st.phase) begin
			case (st.mode)
				MODE_RUN: begin
					if (st.quiet != 16'h0) begin
					end else if (force_pre) begin
						issue = 1'b1;
						icmd = `CMD_PRE;
						iba = force_bank;
						next.open[force_bank] = 1'b0;
						next.act_rdy[force_bank] = mx(st.act_rdy[force_bank], RP_LD);
					end else if (st.debt != 4'h0 && all_idle && st.rfc == 16'h0 &&
							(st.debt == DEBT_MAX || !REQ_VALID)) begin
						issue = 1'b1;
						icmd = `CMD_REF;
						next.rfc = RFC_LD;
						next.debt = st.debt - 4'h1;
					end else if (REQ_VALID) begin
						iba = REQ.bank;
						iaddr = REQ.addr;
						case (REQ.cmd)
							REQ_ACTIVATE: begin
								if (!st.open[REQ.bank] && st.act_rdy[REQ.bank] == 16'h0 &&
										st.rrd == 16'h0 && st.rfc == 16'h0 &&
										st.debt != DEBT_MAX) begin
									issue = 1'b1;
									icmd = `CMD_ACT;
									next.open[REQ.bank] = 1'b1;
									next.age[REQ.bank] = 16'h1;
									next.act_rdy[REQ.bank] = RC_LD;
									next.rrd = RRD_LD;
								end
							end
							REQ_READ: begin
								if (st.open[REQ.bank] && st.age[REQ.bank] >= RCD &&
										st.wtr == 16'h0) begin
									issue = 1'b1;
									icmd = `CMD_RD;
									iaddr[`AUTO_PRECHARGE_BIT] = 1'b0;
								end
							end
							REQ_WRITE, REQ_WRITE_AP: begin
								if (st.open[REQ.bank] && st.age[REQ.bank] >= RCD &&
										st.dqs_cnt == 8'h0) begin
									issue = 1'b1;
									icmd = `CMD_WR;
									iaddr[`AUTO_PRECHARGE_BIT] = (REQ.cmd == REQ_WRITE_AP);
									next.wtr = WTR_LD;
									next.dqs_cnt = DQS_LEN;
									if (REQ.cmd == REQ_WRITE_AP) begin
										next.open[REQ.bank] = 1'b0;
										next.act_rdy[REQ.bank] = mx(st.act_rdy[REQ.bank], WRA_LD);
									end
								end
							end
							REQ_PRECHARGE: begin
								if (!st.open[REQ.bank] || st.age[REQ.bank] >= RAS_MIN) begin
									issue = 1'b1;
									icmd = `CMD_PRE;
									iaddr = 13'h0;
									next.open[REQ.bank] = 1'b0;
									next.act_rdy[REQ.bank] = mx(st.act_rdy[REQ.bank], RP_LD);
								end
							end
							REQ_MODE_SET, REQ_STATUS_READ: begin
								if (all_idle) begin
									issue = 1'b1;
									icmd = `CMD_MRS;
									next.quiet = MRD_LD;
									if (REQ.cmd == REQ_STATUS_READ) begin
										iba = `STATUS_SELECT_BA;
										next.quiet = SRR_LD;
										next.mode = MODE_STATUS_READ;
									end
								end
							end
							REQ_SELF_REFRESH_ENTER: begin
								if (all_idle && st.cke_hold == 16'h0) begin
									issue = 1'b1;
									icmd = `CMD_REF;
									next_cke = 1'b0;
									next.cke_hold = CKE_LD;
									next.mode = MODE_SELF_REFRESH;
								end
							end
							REQ_POWERDOWN_ENTER: begin
								if (st.cke_hold == 16'h0) begin
									issue = 1'b1;
									next_cke = 1'b0;
									next.cke_hold = CKE_LD;
									next.mode = MODE_POWERDOWN;
								end
							end
							default: begin
								issue = 1'b1;
							end
						endcase
						take = issue;
						if (REQ.cmd == REQ_SELF_REFRESH_EXIT || REQ.cmd == REQ_POWERDOWN_EXIT) begin
							issue = 1'b0;
						end
					end
				end
				MODE_STATUS_READ: begin
					if (st.quiet == 16'h0) begin
						issue = 1'b1;
						icmd = `CMD_RD;
						next.quiet = SRC_LD;
						next.mode = MODE_RUN;
					end
				end
				MODE_POWERDOWN: begin
					// Leave power-down on request, or when a refresh or an open row cannot wait.
					if (st.cke_hold == 16'h0 && ((REQ_VALID && REQ.cmd == REQ_POWERDOWN_EXIT) ||
							st.debt == DEBT_MAX || force_pre)) begin
						take = REQ_VALID && REQ.cmd == REQ_POWERDOWN_EXIT;
						next_cke = 1'b1;
						next.cke_hold = CKE_LD;
						next.quiet = XP_LD;
						next.mode = MODE_RUN;
					end
				end
				MODE_SELF_REFRESH: begin
					if (st.cke_hold == 16'h0 && REQ_VALID &&
							REQ.cmd == REQ_SELF_REFRESH_EXIT) begin
						take = 1'b1;
						next_cke = 1'b1;
						next.cke_hold = CKE_LD;
						next.quiet = XSR_LD;
						next.mode = MODE_RUN;
					end
				end
				default: begin
					next.mode = MODE_RUN;
				end
			endcase
			next.pins = {next_cke, 1'b0, icmd, iba, iaddr};
		end
		// First strobe rise one command clock after the clock edge that takes the write.
		next.dqs_oe_n = !(next.dqs_cnt != 8'h0 && next.dqs_cnt <= DQS_DRIVE);
		next.dqs = !next.dqs_oe_n && next.dqs_cnt[0] && next.dqs_cnt > 8'h1;
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			st <= '0;
			st.ck_n <= 1'b1;
			st.mode <= MODE_RUN;
			st.pins <= {1'b1, 1'b0, `CMD_NOP, 2'h0, 13'h0};
			st.age <= '1;
			st.dqs_oe_n <= 1'b1;
		end else begin
			st <= next;
		end
	end

	assign REQ_READY = take;
	assign CK = st.phase;
	assign CK_N = st.ck_n;
	assign CKE = st.pins.cke;
	assign CS_N = st.pins.cs_n;
	assign {RAS_N, CAS_N, WE_N} = st.pins.cmd;
	assign BA = st.pins.ba;
	assign ADDR = st.pins.addr;
	assign DQS_O = st.dqs;
	assign DQS_OE_N = st.dqs_oe_n;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	chk_mode_gap: assert property (issue && icmd == `CMD_MRS |=> !issue [*3])
		else $error("command issued inside mode program gap");
	chk_row_min: assert property (issue && icmd == `CMD_PRE && st.open[iba]
		|-> st.age[iba] >= RAS_MIN)
		else $error("precharge before row open minimum");
	for (genvar g = 0; g < `BANKS; g++) begin : g_bank
		chk_row_max: assert property (st.open[g] |-> st.age[g] <= 16'(ROW_OPEN_MAX_CYC))
			else $error("row open beyond maximum");
	end
	chk_same_bank: assert property (issue && icmd == `CMD_ACT |-> st.age[iba] >= RC)
		else $error("same bank activate too soon");
	chk_refresh_gap: assert property (issue && icmd == `CMD_REF && next_cke
		|=> !(issue && (icmd == `CMD_ACT || icmd == `CMD_REF)) [*7])
		else $error("activate or refresh inside refresh gap");
	chk_access_gap: assert property (issue && st.mode == MODE_RUN &&
		(icmd == `CMD_RD || icmd == `CMD_WR) |-> st.age[iba] >= RCD)
		else $error("access too soon after activate");
	chk_write_read: assert property (issue && icmd == `CMD_WR
		|=> !(issue && icmd == `CMD_RD) [*7])
		else $error("read too soon after write data");
	chk_cke_pulse: assert property ($changed(st.pins.cke)
		|-> $past(st.cke_hold) == 16'h0 ##1 $stable(st.pins.cke))
		else $error("clock enable pulse too short");
	chk_strobe_edge: assert property (issue && icmd == `CMD_WR
		|-> ##3 !st.dqs_oe_n ##1 $rose(st.dqs))
		else $error("write strobe first edge misplaced");
	chk_debt_cap: assert property (st.debt <= DEBT_MAX)
		else $error("too many refreshes postponed");

	cov_activate: cover property (issue && icmd == `CMD_ACT);
	cov_refresh: cover property (issue && icmd == `CMD_REF && next_cke);
	cov_status: cover property (st.mode == MODE_STATUS_READ ##[1:20] issue && icmd == `CMD_RD);
	cov_self_refresh: cover property (st.mode == MODE_SELF_REFRESH ##1 st.mode == MODE_RUN);
endmodule

// ==== lpddr_device_model.sv ====
`timescale 1ns/10ps
// Device side: samples commands on rising command clock edges and counts spacing faults.
// Gaps are in system clock cycles, two per command clock.
module lpddr_device_model #(
	parameter int ROW_MAX = 200
) (
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic        CK,
	input  wire logic        CKE,
	input  wire logic        CS_N,
	input  wire logic        RAS_N,
	input  wire logic        CAS_N,
	input  wire logic        WE_N,
	input  wire logic [1:0]  BA,
	input  wire logic [12:0] ADDR,
	output logic      [15:0] faults,
	output logic      [15:0] refs
);
	int now, t_mrs, t_ref, t_wr, t_srd, t_any, t_exit, t_cke, exit_gap;
	int t_act[4], t_pre[4], t_wra[4];
	logic ck_q, cke_q, in_sr, sel;
	logic [3:0] open;
	logic [2:0] c;

	task automatic gap(input int since, input int min);
		if (now - since < min) faults++;
	endtask

	always @(negedge MCLK) begin
		if (RST) begin
			now = 0; t_mrs = -99999; t_ref = -99999; t_wr = -99999; t_srd = -99999;
			t_any = -99999; t_exit = -99999; t_cke = -99999; exit_gap = 0;
			t_act = '{4{-99999}}; t_pre = '{4{-99999}}; t_wra = '{4{-99999}};
			faults = 16'h0; refs = 16'h0; ck_q = 1'b0; cke_q = 1'b1;
			in_sr = 1'b0; sel = 1'b0; open = 4'h0;
		end else begin
			now++;
			for (int b = 0; b < 4; b++) begin
				if (open[b] && now - t_act[b] > ROW_MAX) begin
					faults++;
					open[b] = 1'b0;
				end
			end
			c = {RAS_N, CAS_N, WE_N};
			if (CK && !ck_q) begin
				if (CKE != cke_q) begin
					gap(t_cke, 2);
					t_cke = now;
					if (!CKE && !CS_N && c == 3'h1) in_sr = 1'b1;
					if (CKE) begin
						exit_gap = in_sr ? 12 : 4;
						t_exit = now;
						in_sr = 1'b0;
					end
				end
				if (CKE && !CS_N && c != 3'h7) begin
					gap(t_mrs, 4);
					gap(t_exit, exit_gap);
					gap(t_srd, 8);
					case (c)
						3'h3: begin
							gap(t_ref, 8);
							gap(t_act[BA], 6);
							gap(t_pre[BA], 2);
							gap(t_wra[BA], 12);
							gap(t_any, 2);
							t_act[BA] = now;
							t_any = now;
							open[BA] = 1'b1;
						end
						3'h5: begin
							gap(t_act[BA], 2);
							gap(t_wr, 8);
							if (sel) t_srd = now;
							sel = 1'b0;
						end
						3'h4: begin
							gap(t_act[BA], 2);
							t_wr = now;
							if (ADDR[10]) begin
								t_wra[BA] = now;
								open[BA] = 1'b0;
							end
						end
						3'h2: begin
							for (int b = 0; b < 4; b++) begin
								if ((ADDR[10] || b == BA) && open[b]) begin
									gap(t_act[b], 4);
									t_pre[b] = now;
									open[b] = 1'b0;
								end
							end
						end
						3'h1: begin
							gap(t_ref, 8);
							if (refs != 0 && now - t_ref > 8 * 780) faults++;
							t_ref = now;
							refs++;
						end
						default: begin
							t_mrs = now;
							sel = (BA == 2'h1);
						end
					endcase
				end
				cke_q = CKE;
			end
			ck_q = CK;
		end
	end
endmodule

// ==== test_lpddr_command_timing_guard.sv ====
`timescale 1ns/10ps
module test_lpddr_command_timing_guard;
	import lpddr_guard_pkg::*;
	typedef struct packed {
		req_type    r;
		logic [2:0] cmd;
		logic       cke;
		logic       chk;
		logic [1:0] ba;
	} row_type;

	logic        MCLK, RST, REQ_VALID, REQ_READY, CK, CK_N, CKE, CS_N, RAS_N, CAS_N, WE_N;
	logic        DQS_O, DQS_OE_N;
	logic [1:0]  BA;
	logic [12:0] ADDR;
	logic [15:0] faults, refs, refs0;
	req_type     REQ;
	int          num_errors, comparisons;
	row_type rows[20] = '{
		'{'{REQ_ACTIVATE, 2'h0, 13'h0123}, 3'h3, 1'b1, 1'b1, 2'h0},
		'{'{REQ_WRITE, 2'h0, 13'h0010}, 3'h4, 1'b1, 1'b1, 2'h0},
		'{'{REQ_READ, 2'h0, 13'h0010}, 3'h5, 1'b1, 1'b1, 2'h0},
		'{'{REQ_PRECHARGE, 2'h0, 13'h0000}, 3'h2, 1'b1, 1'b1, 2'h0},
		'{'{REQ_ACTIVATE, 2'h1, 13'h0042}, 3'h3, 1'b1, 1'b1, 2'h1},
		'{'{REQ_ACTIVATE, 2'h2, 13'h0077}, 3'h3, 1'b1, 1'b1, 2'h2},
		'{'{REQ_WRITE_AP, 2'h1, 13'h0020}, 3'h4, 1'b1, 1'b1, 2'h1},
		'{'{REQ_ACTIVATE, 2'h1, 13'h0043}, 3'h3, 1'b1, 1'b1, 2'h1},
		'{'{REQ_READ, 2'h2, 13'h0008}, 3'h5, 1'b1, 1'b1, 2'h2},
		'{'{REQ_PRECHARGE, 2'h2, 13'h0000}, 3'h2, 1'b1, 1'b1, 2'h2},
		'{'{REQ_PRECHARGE, 2'h1, 13'h0000}, 3'h2, 1'b1, 1'b1, 2'h1},
		'{'{REQ_MODE_SET, 2'h0, 13'h0033}, 3'h0, 1'b1, 1'b1, 2'h0},
		'{'{REQ_STATUS_READ, 2'h0, 13'h0000}, 3'h0, 1'b1, 1'b1, 2'h1},
		'{'{REQ_POWERDOWN_ENTER, 2'h0, 13'h0000}, 3'h7, 1'b0, 1'b0, 2'h0},
		'{'{REQ_POWERDOWN_EXIT, 2'h0, 13'h0000}, 3'h7, 1'b1, 1'b0, 2'h0},
		'{'{REQ_SELF_REFRESH_ENTER, 2'h0, 13'h0000}, 3'h1, 1'b0, 1'b1, 2'h0},
		'{'{REQ_SELF_REFRESH_EXIT, 2'h0, 13'h0000}, 3'h7, 1'b1, 1'b0, 2'h0},
		'{'{REQ_ACTIVATE, 2'h3, 13'h0100}, 3'h3, 1'b1, 1'b1, 2'h3},
		'{'{REQ_PRECHARGE, 2'h3, 13'h0000}, 3'h2, 1'b1, 1'b1, 2'h3},
		'{'{REQ_ACTIVATE, 2'h0, 13'h0055}, 3'h3, 1'b1, 1'b1, 2'h0}
	};
	logic [1:0] walk[7] = '{2'b00, 2'b01, 2'b00, 2'b01, 2'b00, 2'b00, 2'b10};

	lpddr_command_timing_guard #(
		.ROW_OPEN_MAX_CYC(200)
	) dut (
		.MCLK     (MCLK),
		.RST      (RST),
		.REQ      (REQ),
		.REQ_VALID(REQ_VALID),
		.REQ_READY(REQ_READY),
		.CK       (CK),
		.CK_N     (CK_N),
		.CKE      (CKE),
		.CS_N     (CS_N),
		.RAS_N    (RAS_N),
		.CAS_N    (CAS_N),
		.WE_N     (WE_N),
		.BA       (BA),
		.ADDR     (ADDR),
		.DQS_O    (DQS_O),
		.DQS_OE_N (DQS_OE_N)
	);

	lpddr_device_model #(
		.ROW_MAX(200)
	) device (
		.MCLK  (MCLK),
		.RST   (RST),
		.CK    (CK),
		.CKE   (CKE),
		.CS_N  (CS_N),
		.RAS_N (RAS_N),
		.CAS_N (CAS_N),
		.WE_N  (WE_N),
		.BA    (BA),
		.ADDR  (ADDR),
		.faults(faults),
		.refs  (refs)
	);

	initial begin
		MCLK = 1'b0;
		forever #5 MCLK = ~MCLK;
	end

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Called at a falling edge; returns at the falling edge where the pins show the command.
	task automatic issue(input req_type r);
		int n;
		n = 0;
		REQ = r;
		REQ_VALID = 1'b1;
		#1;
		while (REQ_READY !== 1'b1) begin
			n++;
			if (n > 3000) begin
				num_errors++;
				$display("ERROR request wait expected ready seen timeout");
				final_report();
			end
			@(negedge MCLK);
			#1;
		end
		@(negedge MCLK);
		REQ_VALID = 1'b0;
		@(negedge MCLK);
	endtask

	task automatic idle_pins(input string what);
		check({what, " ck"}, 16'h0, CK);
		check({what, " ck_n"}, 16'h1, CK_N);
		check({what, " cke"}, 16'h1, CKE);
		check({what, " pins"}, 16'h7, {CS_N, RAS_N, CAS_N, WE_N});
		check({what, " address"}, 16'h0, {BA, ADDR});
		check({what, " strobe"}, 16'h2, {DQS_OE_N, DQS_O});
		check({what, " ready"}, 16'h0, REQ_READY);
	endtask

	initial begin
		RST = 1'b1;
		REQ_VALID = 1'b0;
		REQ = '0;
		repeat (12) @(negedge MCLK);
		idle_pins("reset");
		RST = 1'b0;
		@(negedge MCLK);
		$display("test reset done");
		foreach (rows[i]) begin
			issue(rows[i].r);
			if (rows[i].chk) check("command", rows[i].cmd, {RAS_N, CAS_N, WE_N});
			check("clock enable", rows[i].cke, CKE);
			if (rows[i].chk) check("bank", rows[i].ba, BA);
			if (rows[i].chk && rows[i].cmd == 3'h3) check("row address", rows[i].r.addr, ADDR);
			if (rows[i].r.cmd == REQ_WRITE_AP) check("auto precharge", 16'h1, ADDR[10]);
		end
		$display("test command table done");
		issue('{REQ_WRITE, 2'h0, 13'h0004});
		for (int k = 0; k < 7; k++) begin
			@(negedge MCLK);
			check("strobe enable", walk[k][1], DQS_OE_N);
			if (k < 6) check("strobe level", walk[k][0], DQS_O);
		end
		issue('{REQ_READ, 2'h0, 13'h0004});
		check("read after write", 16'h5, {RAS_N, CAS_N, WE_N});
		$display("test write strobe done");
		refs0 = refs;
		repeat (1700) @(negedge MCLK);
		check("refresh issued", 16'h1, refs > refs0);
		$display("test refresh and row limit done");
		check("device timing faults", 16'h0, faults);
		issue('{REQ_ACTIVATE, 2'h2, 13'h0011});
		RST = 1'b1;
		repeat (2) @(negedge MCLK);
		idle_pins("second reset");
		RST = 1'b0;
		@(negedge MCLK);
		issue('{REQ_ACTIVATE, 2'h2, 13'h0012});
		check("after reset", 16'h3, {RAS_N, CAS_N, WE_N});
		repeat (40) @(negedge MCLK);
		$display("test second reset done");
		check("device timing faults", 16'h0, faults);
		final_report();
	end
endmodule
